/* File: hdl/asc_ctrl.sv */
`timescale 1ns/1ns
// Summary of operation
// - converter logic paced near 16.667 MHz enable
// - sequencer interrupt leaves only when masked in
// - raw status plus masked status views
// - writing one clears interrupt, zero keeps
// - pending triggers served by priority, zero first
// - per-sequencer trigger source select field
// - software initiate bit triggers processor-sourced sequencer
// - always trigger requests conversions continuously
// - averaging accumulates up to 64 conversions
// - one fifo entry per N conversions
// - averaging off after reset, passthrough
// - single averaging stage for all steps
// - ten-bit result per conversion
// - differential bit selects differential step
// - pair k uses inputs 2k and 2k+1
// - differential codes centred on 0x1ff
// - loopback mode feeds digital path internally
// - reset priority: sequencer 0 highest, 3 lowest
// - disabled sequencer accepts config, never executes
// - step and fifo depths 8, 4, 4, 1
// - fifo word holds result, read pops entry
// - step nibbles; stop after end step
// - sequencer runs only while enabled
module asc_ctrl (
  input wire logic clk,
  input wire logic rst_n,
  input wire asc_pkg::asc_bus_req_t bus,
  output logic [31:0] rdata,
  input wire logic [3:0] periph_evt,
  output logic conv_start,
  output asc_pkg::asc_conv_sel_t conv_sel,
  input wire logic conv_done,
  input wire logic [9:0] conv_data,
  output logic [3:0] seq_irq
);
  // ==========================================================
  // converter clock enable
  logic [15:0] div_acc_r;
  logic adc_ce;
  wire logic [16:0] div_sum = {1'b0, div_acc_r} + asc_pkg::DIV_STEP;
  wire logic div_wrap = div_sum >= asc_pkg::DIV_WRAP;
  wire logic [16:0] div_nxt = div_wrap ? div_sum - asc_pkg::DIV_WRAP : div_sum;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      div_acc_r <= 16'h0000;
      adc_ce <= 1'b0;
    end else begin
      div_acc_r <= div_nxt[15:0];
      adc_ce <= div_wrap;
    end
  end

  // ==========================================================
  // global registers
  logic [3:0] actss_r;
  logic [3:0] im_r;
  logic [3:0] ris_r;
  logic [15:0] emux_r;
  logic [15:0] sspri_r;
  logic [2:0] sac_r;
  logic lb_r;
  logic [3:0] pending_r;
  logic [9:0] lb_cnt_r;

  wire logic wr_actss = bus.wr && bus.addr == asc_pkg::OFS_ACTSS;
  wire logic wr_im = bus.wr && bus.addr == asc_pkg::OFS_IM;
  wire logic wr_isc = bus.wr && bus.addr == asc_pkg::OFS_ISC;
  wire logic wr_emux = bus.wr && bus.addr == asc_pkg::OFS_EMUX;
  wire logic wr_sspri = bus.wr && bus.addr == asc_pkg::OFS_SSPRI;
  wire logic wr_pssi = bus.wr && bus.addr == asc_pkg::OFS_PSSI;
  wire logic wr_sac = bus.wr && bus.addr == asc_pkg::OFS_SAC;
  wire logic wr_tmlb = bus.wr && bus.addr == asc_pkg::OFS_TMLB;

  // sequencer engine state
  asc_pkg::asc_state_t state_r;
  logic [1:0] cur_r;
  logic [2:0] step_r;
  logic [5:0] avg_cnt_r;
  logic [15:0] acc_r;
  logic done_r;
  logic [9:0] done_data_r;
  logic conv_start_r;
  asc_pkg::asc_conv_sel_t conv_sel_r;
  logic [3:0] seq_irq_r;
  logic [31:0] rdata_r;

  wire logic [3:0][31:0] mux_w;
  wire logic [3:0][31:0] ctl_w;
  wire logic [3:0][31:0] seq_rd;
  wire logic [3:0] trig_hit;
  wire logic [3:0] pending_nxt;
  wire logic [3:0] soft_hit;
  wire logic [3:0] fifo_full;
  wire logic [3:0][3:0] fifo_cnt;
  wire logic [3:0] fifo_pop;
  wire logic [3:0] req = pending_r & actss_r;
  wire logic any_req = |req;
  logic [1:0] best;
  logic [3:0] take;

  // ==========================================================
  // arbitration
  // lowest value wins
  always_comb begin
    logic found;
    found = 1'b0;
    best = 2'd0;
    for (int i = 0; i < 4; i++) begin
      if (req[i] && (!found || sspri_r[4*i +: 2] < sspri_r[4*best +: 2])) begin
        best = 2'(i);
        found = 1'b1;
      end
    end
  end

  wire logic grant = adc_ce && state_r == asc_pkg::ASC_IDLE && any_req;

  always_comb begin
    take = 4'h0;
    take[best] = grant;
  end

  // ==========================================================
  // step decode
  wire logic [31:0] cur_ctl = ctl_w[cur_r];
  wire logic [31:0] cur_mux = mux_w[cur_r];
  wire logic [3:0] step_ctl = cur_ctl[{step_r, 2'b00} +: 4];
  wire logic [3:0] step_mux = cur_mux[{step_r, 2'b00} +: 4];
  wire logic [3:0] cur_depth = asc_pkg::SEQ_DEPTH[{cur_r, 2'b00} +: 4];
  wire logic last_step = step_ctl[asc_pkg::CTL_END] || {1'b0, step_r} == cur_depth - 4'd1;
  wire logic step_diff = step_ctl[asc_pkg::CTL_DIFF];
  // pair k maps to even input 2k
  wire logic [2:0] step_ain = step_diff ? {step_mux[1:0], 1'b0} : step_mux[2:0];

  // ==========================================================
  // averaging
  // one count shared by all steps
  wire logic [2:0] sac_eff = sac_r > asc_pkg::AVG_MAX_LOG ? asc_pkg::AVG_MAX_LOG : sac_r;
  wire logic [6:0] avg_span = 7'h01 << sac_eff;
  wire logic [6:0] avg_lim7 = avg_span - 7'h01;
  wire logic [5:0] avg_lim = avg_lim7[5:0];
  wire logic [9:0] sample = lb_r ? lb_cnt_r : done_data_r;
  wire logic sample_ok = lb_r || done_r;
  wire logic [15:0] acc_sum = acc_r + {6'h00, sample};
  wire logic [15:0] acc_shift = acc_sum >> sac_eff;
  // zero shift when averaging is off
  wire logic [9:0] push_data = acc_shift[9:0];
  wire logic consume = adc_ce && state_r == asc_pkg::ASC_WAIT && actss_r[cur_r] && sample_ok;
  wire logic push = consume && avg_cnt_r == avg_lim;
  wire logic [3:0] push_vec = push ? 4'h1 << cur_r : 4'h0;
  wire logic [3:0] ris_set = step_ctl[asc_pkg::CTL_IE] ? push_vec : 4'h0;
  wire logic abort = adc_ce && state_r != asc_pkg::ASC_IDLE && !actss_r[cur_r];

  // ==========================================================
  // per-sequencer logic
  genvar n;
  generate
    for (n = 0; n < 4; n++) begin : g_seq
      localparam logic [3:0] DEPTH = asc_pkg::SEQ_DEPTH[4*n +: 4];
      localparam logic [31:0] NIB_MASK = 32'hffff_ffff >> (32 - 4 * int'(DEPTH));
      localparam logic [31:0] CTL_RST = (n == 3) ? asc_pkg::SSCTL3_RST : 32'h0000_0000;
      localparam logic [11:0] BASE = asc_pkg::OFS_SS_BASE + 12'(n) * asc_pkg::OFS_SS_STRIDE;
      logic [31:0] mux_r;
      logic [31:0] ctl_r;
      logic [9:0] mem [8];
      logic [2:0] wp_r;
      logic [2:0] rp_r;
      logic [3:0] cnt_r;
      wire logic hit_mux = bus.addr == BASE + asc_pkg::SUB_MUX;
      wire logic hit_ctl = bus.addr == BASE + asc_pkg::SUB_CTL;
      wire logic hit_fifo = bus.addr == BASE + asc_pkg::SUB_FIFO;
      wire logic hit_fstat = bus.addr == BASE + asc_pkg::SUB_FSTAT;
      wire logic [3:0] code = emux_r[4*n +: 4];
      wire logic [3:0] code_m1 = code - 4'd1;
      wire logic empty = cnt_r == 4'd0;
      wire logic full = cnt_r == DEPTH;
      wire logic pop = bus.rd && hit_fifo && !empty;
      wire logic do_push = push_vec[n] && !full;
      wire logic [31:0] fstat = (32'(full) << asc_pkg::FSTAT_FULL) | (32'(empty) << asc_pkg::FSTAT_EMPTY) |
        {25'h0, rp_r, 1'b0, wp_r};

      assign soft_hit[n] = wr_pssi && bus.wdata[n] && code == asc_pkg::TRIG_PROC;
      assign trig_hit[n] = soft_hit[n] || code == asc_pkg::TRIG_ALWAYS ||
        (code != 4'h0 && code <= asc_pkg::PERIPH_EVTS && periph_evt[code_m1[1:0]]);
      assign mux_w[n] = mux_r;
      assign ctl_w[n] = ctl_r;
      assign fifo_full[n] = full;
      assign fifo_cnt[n] = cnt_r;
      assign fifo_pop[n] = pop;
      assign seq_rd[n] = hit_mux ? mux_r : hit_ctl ? ctl_r :
        hit_fifo ? {22'h0, mem[rp_r]} : hit_fstat ? fstat : 32'h0000_0000;

      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          mux_r <= 32'h0000_0000;
          ctl_r <= CTL_RST;
        end else if (bus.wr) begin
          if (hit_mux) mux_r <= bus.wdata & NIB_MASK;
          if (hit_ctl) ctl_r <= bus.wdata & NIB_MASK;
        end
      end

      assign pending_nxt[n] = actss_r[n] && (trig_hit[n] || (pending_r[n] && !take[n]));

      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          wp_r <= 3'h0;
          rp_r <= 3'h0;
          cnt_r <= 4'h0;
        end else begin
          if (do_push) wp_r <= ({1'b0, wp_r} == DEPTH - 4'd1) ? 3'h0 : wp_r + 3'h1;
          if (pop) rp_r <= ({1'b0, rp_r} == DEPTH - 4'd1) ? 3'h0 : rp_r + 3'h1;
          if (do_push && !pop) cnt_r <= cnt_r + 4'd1;
          else if (pop && !do_push) cnt_r <= cnt_r - 4'd1;
        end
      end

      // storage carries no reset, a read while empty returns mem[rp_r] as it stands
      always_ff @(posedge clk) begin
        if (do_push) mem[wp_r] <= push_data;
      end
    end
  endgenerate

  // ==========================================================
  // global register writes
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      actss_r <= 4'h0;
      im_r <= 4'h0;
      emux_r <= 16'h0000;
      sspri_r <= asc_pkg::SSPRI_RST;
      sac_r <= 3'h0;
      lb_r <= 1'b0;
    end else begin
      if (wr_actss) actss_r <= bus.wdata[3:0];
      if (wr_im) im_r <= bus.wdata[3:0];
      if (wr_emux) emux_r <= bus.wdata[15:0];
      if (wr_sspri) sspri_r <= bus.wdata[15:0] & asc_pkg::SSPRI_MASK;
      if (wr_sac) sac_r <= bus.wdata[2:0];
      if (wr_tmlb) lb_r <= bus.wdata[0];
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pending_r <= 4'h0;
    end else begin
      pending_r <= pending_nxt;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ris_r <= 4'h0;
    end else begin
      ris_r <= ris_set | (ris_r & ~(wr_isc ? bus.wdata[3:0] : 4'h0));
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      seq_irq_r <= 4'h0;
    end else begin
      seq_irq_r <= ris_r & im_r;
    end
  end

  // ==========================================================
  // sequence engine
  // converter done may land between enables, so it is held
  // ten-bit result captured
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      done_r <= 1'b0;
      done_data_r <= 10'h000;
    end else if (conv_done) begin
      done_r <= 1'b1;
      done_data_r <= conv_data;
    end else if (consume || (adc_ce && state_r == asc_pkg::ASC_CONV)) begin
      done_r <= 1'b0;
    end
  end

  // one sequencer, whole sequence, then re-arbitrate
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= asc_pkg::ASC_IDLE;
      cur_r <= 2'd0;
      step_r <= 3'd0;
      avg_cnt_r <= 6'd0;
      acc_r <= 16'h0000;
      conv_start_r <= 1'b0;
      conv_sel_r <= '0;
      lb_cnt_r <= 10'h000;
    end else begin
      conv_start_r <= 1'b0;
      if (abort) begin
        state_r <= asc_pkg::ASC_IDLE;
      end else if (adc_ce) begin
        unique case (state_r)
          asc_pkg::ASC_IDLE: begin
            if (any_req) begin
              cur_r <= best;
              step_r <= 3'd0;
              avg_cnt_r <= 6'd0;
              acc_r <= 16'h0000;
              state_r <= asc_pkg::ASC_CONV;
            end
          end
          asc_pkg::ASC_CONV: begin
            conv_start_r <= !lb_r;
            conv_sel_r <= '{ain: step_ain, diff: step_diff, temp: step_ctl[asc_pkg::CTL_TS]};
            state_r <= asc_pkg::ASC_WAIT;
          end
          asc_pkg::ASC_WAIT: begin
            if (sample_ok) begin
              if (lb_r) lb_cnt_r <= lb_cnt_r + 10'h001;
              if (push) begin
                acc_r <= 16'h0000;
                avg_cnt_r <= 6'd0;
                if (last_step) begin
                  state_r <= asc_pkg::ASC_IDLE;
                end else begin
                  step_r <= step_r + 3'd1;
                  state_r <= asc_pkg::ASC_CONV;
                end
              end else begin
                acc_r <= acc_sum;
                avg_cnt_r <= avg_cnt_r + 6'd1;
                state_r <= asc_pkg::ASC_CONV;
              end
            end
          end
          default: state_r <= asc_pkg::ASC_IDLE;
        endcase
      end
    end
  end

  // ==========================================================
  // register read
  wire logic [31:0] seq_rd_any = seq_rd[0] | seq_rd[1] | seq_rd[2] | seq_rd[3];
  wire logic [31:0] rd_mux =
    bus.addr == asc_pkg::OFS_ACTSS ? {28'h0, actss_r} :
    bus.addr == asc_pkg::OFS_RIS ? {28'h0, ris_r} :
    bus.addr == asc_pkg::OFS_IM ? {28'h0, im_r} :
    bus.addr == asc_pkg::OFS_ISC ? {28'h0, ris_r & im_r} :
    bus.addr == asc_pkg::OFS_EMUX ? {16'h0, emux_r} :
    bus.addr == asc_pkg::OFS_SSPRI ? {16'h0, sspri_r} :
    bus.addr == asc_pkg::OFS_SAC ? {29'h0, sac_r} :
    bus.addr == asc_pkg::OFS_TMLB ? {31'h0, lb_r} : seq_rd_any;

  // read data valid only in the cycle after the strobe
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_r <= 32'h0000_0000;
    end else begin
      rdata_r <= bus.rd ? rd_mux : 32'h0000_0000;
    end
  end

  assign rdata = rdata_r;
  assign conv_start = conv_start_r;
  assign conv_sel = conv_sel_r;
  assign seq_irq = seq_irq_r;

  // ==========================================================
  // checks
  logic [3:0] req_seen_r;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) req_seen_r <= 4'h0;
    else req_seen_r <= req;
  end
  wire logic [1:0] cur_pri = sspri_r[4*cur_r +: 2];
  wire logic prio_min_ok = (!req_seen_r[0] || cur_pri <= sspri_r[1:0]) &&
    (!req_seen_r[1] || cur_pri <= sspri_r[5:4]) &&
    (!req_seen_r[2] || cur_pri <= sspri_r[9:8]) &&
    (!req_seen_r[3] || cur_pri <= sspri_r[13:12]);

  property p_ce_rate;
    @(posedge clk) disable iff (!rst_n) !adc_ce ##1 !adc_ce |=> adc_ce;
  endproperty
  a_ce_rate: assert property (p_ce_rate) else $error("enable gap too long");

  property p_irq_mask;
    @(posedge clk) disable iff (!rst_n) ##1 (seq_irq == $past(ris_r & im_r));
  endproperty
  a_irq_mask: assert property (p_irq_mask) else $error("irq not masked raw");

  property p_isc_view;
    @(posedge clk) disable iff (!rst_n)
      (bus.rd && bus.addr == asc_pkg::OFS_ISC) |=> rdata[3:0] == $past(ris_r & im_r);
  endproperty
  a_isc_view: assert property (p_isc_view) else $error("masked status wrong");

  property p_isc_clear;
    @(posedge clk) disable iff (!rst_n)
      wr_isc |=> (ris_r & $past(bus.wdata[3:0] & ~ris_set)) == 4'h0;
  endproperty
  a_isc_clear: assert property (p_isc_clear) else $error("interrupt not cleared");

  property p_prio;
    @(posedge clk) disable iff (!rst_n) grant |=> state_r == asc_pkg::ASC_CONV && prio_min_ok;
  endproperty
  a_prio: assert property (p_prio) else $error("lower priority granted");

  property p_soft;
    @(posedge clk) disable iff (!rst_n)
      |(soft_hit & actss_r) |=> (pending_r & $past(soft_hit & actss_r)) == $past(soft_hit & actss_r);
  endproperty
  a_soft: assert property (p_soft) else $error("software trigger lost");

  property p_passthru;
    @(posedge clk) disable iff (!rst_n) (push && sac_r == 3'h0) |-> push_data == sample;
  endproperty
  a_passthru: assert property (p_passthru) else $error("result altered");

  property p_pair;
    @(posedge clk) disable iff (!rst_n) (conv_start && conv_sel.diff) |-> !conv_sel.ain[0];
  endproperty
  a_pair: assert property (p_pair) else $error("odd input as positive");

  property p_disable;
    @(posedge clk) disable iff (!rst_n) abort |=> state_r == asc_pkg::ASC_IDLE && !conv_start;
  endproperty
  a_disable: assert property (p_disable) else $error("disabled sequencer ran");

  property p_pop;
    @(posedge clk) disable iff (!rst_n)
      (fifo_pop[0] && !push_vec[0]) |=> fifo_cnt[0] == $past(fifo_cnt[0]) - 4'd1;
  endproperty
  a_pop: assert property (p_pop) else $error("fifo read did not pop");

  property p_full_hold;
    @(posedge clk) disable iff (!rst_n) (fifo_full[3] && !fifo_pop[3]) |=> fifo_cnt[3] == 4'd1;
  endproperty
  a_full_hold: assert property (p_full_hold) else $error("full fifo overrun");

  property p_one_conv;
    @(posedge clk) disable iff (!rst_n)
      conv_start |=> !conv_start && (state_r == asc_pkg::ASC_WAIT || $past(abort));
  endproperty
  a_one_conv: assert property (p_one_conv) else $error("overlapping conversions");

  c_grant_low: cover property (@(posedge clk) disable iff (!rst_n) grant && best == 2'd3);
  c_avg_push: cover property (@(posedge clk) disable iff (!rst_n) push && sac_r != 3'h0);
  c_lb_push: cover property (@(posedge clk) disable iff (!rst_n) push && lb_r);
  c_irq: cover property (@(posedge clk) disable iff (!rst_n) |seq_irq);
endmodule : asc_ctrl

/* File: inc/asc_pkg.sv */
package asc_pkg;
  // ==========================================================
  // timing
  localparam int unsigned CLK_KHZ = 20000;
  localparam int unsigned ADC_TARGET_KHZ = 16667;
  localparam logic [16:0] DIV_STEP = 17'(ADC_TARGET_KHZ);
  localparam logic [16:0] DIV_WRAP = 17'(CLK_KHZ);
  // ==========================================================
  // register offsets (byte addresses)
  localparam logic [11:0] OFS_ACTSS = 12'h000;
  localparam logic [11:0] OFS_RIS = 12'h004;
  localparam logic [11:0] OFS_IM = 12'h008;
  localparam logic [11:0] OFS_ISC = 12'h00c;
  localparam logic [11:0] OFS_EMUX = 12'h014;
  localparam logic [11:0] OFS_SSPRI = 12'h020;
  localparam logic [11:0] OFS_PSSI = 12'h028;
  localparam logic [11:0] OFS_SAC = 12'h030;
  localparam logic [11:0] OFS_TMLB = 12'h100;
  localparam logic [11:0] OFS_SS_BASE = 12'h040;
  localparam logic [11:0] OFS_SS_STRIDE = 12'h020;
  localparam logic [11:0] SUB_MUX = 12'h000;
  localparam logic [11:0] SUB_CTL = 12'h004;
  localparam logic [11:0] SUB_FIFO = 12'h008;
  localparam logic [11:0] SUB_FSTAT = 12'h00c;
  // ==========================================================
  // reset values
  localparam logic [15:0] SSPRI_RST = 16'h3210;
  localparam logic [15:0] SSPRI_MASK = 16'h3333;
  localparam logic [31:0] SSCTL3_RST = 32'h0000_0002;
  // ==========================================================
  // fields
  localparam int unsigned CTL_DIFF = 0;
  localparam int unsigned CTL_END = 1;
  localparam int unsigned CTL_IE = 2;
  localparam int unsigned CTL_TS = 3;
  localparam int unsigned FSTAT_EMPTY = 8;
  localparam int unsigned FSTAT_FULL = 12;
  localparam logic [3:0] TRIG_PROC = 4'h0;
  localparam logic [3:0] TRIG_ALWAYS = 4'hf;
  localparam logic [3:0] PERIPH_EVTS = 4'h4;
  localparam logic [2:0] AVG_MAX_LOG = 3'h6;
  // steps per sequencer, nibble n belongs to sequencer n
  localparam logic [15:0] SEQ_DEPTH = 16'h1448;
  // ==========================================================
  // types
  typedef enum logic [1:0] {
    ASC_IDLE = 2'b00,
    ASC_CONV = 2'b01,
    ASC_WAIT = 2'b11
  } asc_state_t;

  typedef struct packed {
    logic [11:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } asc_bus_req_t;

  typedef struct packed {
    logic [2:0] ain;
    logic diff;
    logic temp;
  } asc_conv_sel_t;
endpackage : asc_pkg

/* File: testbench/asc_ctrl_test.sv */
`timescale 1ns/1ns
module asc_ctrl_test;
  // ==========================================================
  // signals
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  asc_pkg::asc_bus_req_t bus = '0;
  logic [31:0] rdata;
  logic [3:0] periph_evt = 4'h0;
  logic conv_start;
  asc_pkg::asc_conv_sel_t conv_sel;
  asc_pkg::asc_conv_sel_t last_sel = '0;
  logic conv_done = 1'b0;
  logic [9:0] conv_data = 10'h000;
  logic [3:0] seq_irq;
  logic [2:0] cdly = 3'h0;
  logic [31:0] v = 32'h0;
  int nconv = 0;
  int n0 = 0;
  int cyc = 0;
  int err_count = 0;
  int total_checks = 0;

  always #25 clk = ~clk;

  asc_ctrl DUT (
    .clk(clk),
    .rst_n(rst_n),
    .bus(bus),
    .rdata(rdata),
    .periph_evt(periph_evt),
    .conv_start(conv_start),
    .conv_sel(conv_sel),
    .conv_done(conv_done),
    .conv_data(conv_data),
    .seq_irq(seq_irq)
  );

  // ==========================================================
  // converter stand-in and run limit
  // result of conversion j is 0x100 + 2j; data line toggles between results
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_count++;
      close_out();
    end
  end

  always @(posedge clk) begin
    conv_done <= 1'b0;
    conv_data <= ~conv_data;
    if (conv_start) begin
      nconv <= nconv + 1;
      last_sel <= conv_sel;
      cdly <= 3'h3;
    end else if (cdly != 3'h0) begin
      cdly <= cdly - 3'h1;
      if (cdly == 3'h1) begin
        conv_done <= 1'b1;
        conv_data <= 10'h100 + 10'(2 * (nconv - 1));
      end
    end
  end

  // ==========================================================
  // tasks
  task automatic close_out();
    if (err_count == 0 && total_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : close_out

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("ERROR %0t: got %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    bus.wr <= 1'b0;
    @(posedge clk);
  endtask : wr

  // read data stands only in the cycle after the strobe
  task automatic rd(input logic [11:0] a, output logic [31:0] d);
    bus <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    bus.rd <= 1'b0;
    #1 d = rdata;
    @(posedge clk);
  endtask : rd

  task automatic rchk(input logic [11:0] a, input logic [31:0] exp);
    rd(a, v);
    chk(v, exp);
  endtask : rchk

  function automatic logic [11:0] sa(input logic [1:0] n, input logic [11:0] sub);
    return asc_pkg::OFS_SS_BASE + asc_pkg::OFS_SS_STRIDE * {10'h0, n} + sub;
  endfunction : sa

  task automatic wait_conv(input int n);
    for (int k = 0; k < 300 && nconv < n; k++) @(posedge clk);
    chk(32'(nconv >= n), 32'h1);
  endtask : wait_conv

  task automatic wait_fifo(input logic [1:0] n);
    v = 32'h100;
    for (int k = 0; k < 40 && v[8] !== 1'b0; k++) rd(sa(n, asc_pkg::SUB_FSTAT), v);
    chk({31'h0, v[8]}, 32'h0);
  endtask : wait_fifo

  task automatic pulse_evt();
    periph_evt <= 4'h1;
    @(posedge clk);
    periph_evt <= 4'h0;
    @(posedge clk);
  endtask : pulse_evt

  // ==========================================================
  // main sequence
  initial begin
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    rchk(asc_pkg::OFS_SSPRI, 32'h3210);
    rchk(asc_pkg::OFS_SAC, 32'h0);
    rchk(sa(2'd3, asc_pkg::SUB_CTL), 32'h2);
    rchk(sa(2'd0, asc_pkg::SUB_FSTAT), 32'h100);
    rchk(12'h1f0, 32'h0);
    // single-ended step with interrupt, masked in
    wr(sa(2'd0, asc_pkg::SUB_MUX), 32'h5);
    wr(sa(2'd0, asc_pkg::SUB_CTL), 32'h6);
    wr(asc_pkg::OFS_IM, 32'h1);
    wr(asc_pkg::OFS_ACTSS, 32'h1);
    wr(asc_pkg::OFS_PSSI, 32'h1);
    wait_conv(1);
    chk({27'h0, last_sel}, {27'h0, 3'h5, 2'b00});
    wait_fifo(2'd0);
    rchk(sa(2'd0, asc_pkg::SUB_FIFO), 32'h100);
    rchk(asc_pkg::OFS_RIS, 32'h1);
    chk({28'h0, seq_irq}, 32'h1);
    wr(asc_pkg::OFS_ISC, 32'h0);
    rchk(asc_pkg::OFS_ISC, 32'h1);
    wr(asc_pkg::OFS_ISC, 32'h1);
    rchk(asc_pkg::OFS_RIS, 32'h0);
    chk({28'h0, seq_irq}, 32'h0);
    // mask cleared: raw view only
    wr(asc_pkg::OFS_IM, 32'h0);
    wr(asc_pkg::OFS_PSSI, 32'h1);
    wait_conv(2);
    wait_fifo(2'd0);
    rchk(asc_pkg::OFS_RIS, 32'h1);
    rchk(asc_pkg::OFS_ISC, 32'h0);
    chk({28'h0, seq_irq}, 32'h0);
    wr(asc_pkg::OFS_ISC, 32'h1);
    rchk(sa(2'd0, asc_pkg::SUB_FIFO), 32'h102);
    // differential pair 3, reconfigured while disabled
    wr(asc_pkg::OFS_ACTSS, 32'h0);
    wr(sa(2'd0, asc_pkg::SUB_MUX), 32'h3);
    wr(sa(2'd0, asc_pkg::SUB_CTL), 32'h3);
    wr(asc_pkg::OFS_ACTSS, 32'h1);
    wr(asc_pkg::OFS_PSSI, 32'h1);
    wait_conv(3);
    chk({27'h0, last_sel}, {27'h0, 3'h6, 2'b10});
    wait_fifo(2'd0);
    rd(sa(2'd0, asc_pkg::SUB_FIFO), v);
    // both triggered at once, sequencer 1 given priority 0
    wr(sa(2'd1, asc_pkg::SUB_MUX), 32'h2);
    wr(sa(2'd1, asc_pkg::SUB_CTL), 32'h2);
    wr(asc_pkg::OFS_SSPRI, 32'h3201);
    wr(asc_pkg::OFS_ACTSS, 32'h3);
    wr(asc_pkg::OFS_PSSI, 32'h3);
    wait_conv(4);
    chk({29'h0, last_sel.ain}, 32'h2);
    wait_conv(5);
    chk({29'h0, last_sel.ain}, 32'h6);
    wait_fifo(2'd0);
    rd(sa(2'd0, asc_pkg::SUB_FIFO), v);
    // averaging over four conversions of the differential step
    wr(asc_pkg::OFS_SAC, 32'h2);
    n0 = nconv;
    wr(asc_pkg::OFS_PSSI, 32'h1);
    wait_conv(n0 + 4);
    wait_fifo(2'd0);
    chk(32'(nconv), 32'(n0 + 4));
    rchk(sa(2'd0, asc_pkg::SUB_FIFO), 32'(32'h100 + 2 * n0 + 3));
    rd(sa(2'd0, asc_pkg::SUB_FSTAT), v);
    chk({31'h0, v[8]}, 32'h1);
    wr(asc_pkg::OFS_SAC, 32'h0);
    // peripheral trigger ignored while disabled, taken once enabled
    wr(sa(2'd2, asc_pkg::SUB_MUX), 32'h7);
    wr(sa(2'd2, asc_pkg::SUB_CTL), 32'ha);
    wr(asc_pkg::OFS_EMUX, 32'h0100);
    wr(asc_pkg::OFS_ACTSS, 32'h0);
    n0 = nconv;
    pulse_evt();
    repeat (30) @(posedge clk);
    chk(32'(nconv), 32'(n0));
    wr(asc_pkg::OFS_ACTSS, 32'h4);
    pulse_evt();
    wait_conv(n0 + 1);
    chk({29'h0, last_sel.ain}, 32'h7);
    chk({31'h0, last_sel.temp}, 32'h1);
    // always trigger keeps requesting until disabled
    wr(asc_pkg::OFS_EMUX, 32'hf000);
    wr(asc_pkg::OFS_ACTSS, 32'h8);
    n0 = nconv;
    wait_conv(n0 + 3);
    wr(asc_pkg::OFS_ACTSS, 32'h0);
    repeat (6) @(posedge clk);
    n0 = nconv;
    repeat (30) @(posedge clk);
    chk(32'(nconv), 32'(n0));
    // loopback fills the fifo without a converter request
    wr(asc_pkg::OFS_TMLB, 32'h1);
    wr(asc_pkg::OFS_ACTSS, 32'h1);
    wr(asc_pkg::OFS_PSSI, 32'h1);
    wait_fifo(2'd0);
    chk(32'(nconv), 32'(n0));
    close_out();
  end
endmodule : asc_ctrl_test
